// *** hw/ufdma_pkg.sv ***
// Purpose: shared constants and carriers of the fifo control and dma ready block
// Assumes: one 10 MHz clock, AHB-Lite word access
// Notes:   byte offsets are word aligned, index is haddr[4:2]
package ufdma_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          FIFO_DEPTH    = 16;
    localparam logic [4:0]  FIFO_FULL_CNT = 5'h10;
    localparam logic [4:0]  HOLD_CNT      = 5'h01;
    localparam logic [2:0]  IDX_FIFO_CTRL = 3'h0;
    localparam logic [2:0]  IDX_TX_DATA   = 3'h1;
    localparam logic [2:0]  IDX_RX_DATA   = 3'h2;
    localparam logic [2:0]  IDX_STATUS    = 3'h3;
    localparam logic [2:0]  IDX_IRQ_STAT  = 3'h4;
    localparam logic [2:0]  IDX_IRQ_MASK  = 3'h5;
    localparam int          FC_EN_BIT     = 0;
    localparam int          FC_RXCLR_BIT  = 1;
    localparam int          FC_TXCLR_BIT  = 2;
    localparam int          FC_DMA_BIT    = 3;
    localparam int          FC_TRIG_LSB   = 6;
    localparam int          ST_TXCNT_LSB  = 0;
    localparam int          ST_RXCNT_LSB  = 8;
    localparam int          ST_TXREQ_BIT  = 16;
    localparam int          ST_RXREQ_BIT  = 17;
    localparam int          IRQ_RX_TRIG   = 0;
    localparam int          IRQ_TX_SPACE  = 1;
    localparam int          IRQ_RX_TOUT   = 2;
    localparam int          IRQ_RX_OVER   = 3;
    localparam logic [1:0]  TRIG_RESET    = 2'h0;
    localparam logic [4:0]  TRIG_LVL_0    = 5'h01;
    localparam logic [4:0]  TRIG_LVL_1    = 5'h04;
    localparam logic [4:0]  TRIG_LVL_2    = 5'h08;
    localparam logic [4:0]  TRIG_LVL_3    = 5'h0E;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ufdma_char_t;

    function automatic logic [4:0] ufdma_trig_level(input logic [1:0] code);
        case (code)
            2'h0:    ufdma_trig_level = TRIG_LVL_0;
            2'h1:    ufdma_trig_level = TRIG_LVL_1;
            2'h2:    ufdma_trig_level = TRIG_LVL_2;
            default: ufdma_trig_level = TRIG_LVL_3;
        endcase
    endfunction
endpackage

// *** hw/ufdma_top.sv ***
// Purpose: tx/rx fifos of one serial channel with fifo control and dma ready pins
// Assumes: shift registers and host bus run on hclk; AHB-Lite slave, zero wait
// Notes:   fifos are cleared whenever the enable bit changes
`timescale 1ns/1ns
module ufdma_top
    import ufdma_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire ufdma_char_t rx_char,
    input  wire logic        rx_timeout,
    output ufdma_char_t      tx_char,
    input  wire logic        tx_char_ready,
    output logic             tx_dma_request_n,
    output logic             rx_dma_request_n,
    output logic             tx_irq_cond,
    output logic             rx_irq_cond,
    output logic             irq
);
    typedef struct packed {
        logic                 fifo_en;
        logic                 dma_mode;
        logic [1:0]           trig;
        logic [15:0][7:0]     tx_mem;
        logic [3:0]           tx_wp;
        logic [3:0]           tx_rp;
        logic [4:0]           tx_cnt;
        logic [15:0][7:0]     rx_mem;
        logic [3:0]           rx_wp;
        logic [3:0]           rx_rp;
        logic [4:0]           rx_cnt;
        logic                 rx_active;
        logic                 tx_cond_d;
        logic                 rx_cond_d;
        logic [3:0]           irq_status;
        logic [3:0]           irq_mask;
        logic                 ph_write;
        logic [2:0]           ph_idx;
        logic [31:0]          rdata;
    } ufdma_state_t;

    ufdma_state_t s;
    ufdma_state_t next_s;

    logic       blk_mode;
    logic [4:0] cap;
    logic [4:0] trig_lvl;
    logic       addr_ok;
    logic       wr_ctrl;
    logic       wr_tx;
    logic       wr_stat;
    logic       wr_mask;
    logic       rd_rx;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_clr;
    logic       rx_clr;
    logic       en_change;
    logic       tx_cond;
    logic       rx_cond;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [31:0] rd_val;

    // the holding register of non-fifo mode is a one-deep fifo
    assign blk_mode = s.fifo_en & s.dma_mode;
    assign cap      = s.fifo_en ? FIFO_FULL_CNT : HOLD_CNT;
    assign trig_lvl = ufdma_trig_level(s.trig);

    // zero wait slave, every answer OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s.rdata;

    assign tx_char.valid = (s.tx_cnt != 5'h00);
    assign tx_char.data  = s.tx_mem[s.tx_rp];

    // tx request pin
    always_comb
    begin
        if (blk_mode)
        begin
            tx_dma_request_n = (s.tx_cnt == FIFO_FULL_CNT);
        end
        else
        begin
            tx_dma_request_n = (s.tx_cnt != 5'h00);
        end
    end

    // rx request pin
    always_comb
    begin
        if (blk_mode)
        begin
            rx_dma_request_n = ~s.rx_active;
        end
        else
        begin
            rx_dma_request_n = (s.rx_cnt == 5'h00);
        end
    end

    // interrupt conditions are levels; their rising edges feed sticky status
    always_comb
    begin
        if (blk_mode)
        begin
            tx_cond = (s.tx_cnt != FIFO_FULL_CNT);
        end
        else
        begin
            tx_cond = (s.tx_cnt == 5'h00);
        end
        if (s.fifo_en)
        begin
            rx_cond = (s.rx_cnt >= trig_lvl);
        end
        else
        begin
            rx_cond = (s.rx_cnt != 5'h00);
        end
    end

    assign tx_irq_cond = tx_cond;
    assign rx_irq_cond = rx_cond;
    assign irq         = |(s.irq_status & s.irq_mask);

    // address phase: read value is captured now so hrdata comes from a flop
    assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign rd_rx   = addr_ok & ~hwrite & (haddr[4:2] == IDX_RX_DATA) & (s.rx_cnt != 5'h00);

    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (haddr[4:2])
            IDX_FIFO_CTRL:
            begin
                // clear bits and bits 5-4 always read zero
                rd_val[FC_EN_BIT]                 = s.fifo_en;
                rd_val[FC_DMA_BIT]                = s.dma_mode;
                rd_val[FC_TRIG_LSB +: 2]          = s.trig;
            end
            IDX_TX_DATA:
            begin
                rd_val[4:0] = s.tx_cnt;
            end
            IDX_RX_DATA:
            begin
                if (s.rx_cnt != 5'h00)
                begin
                    rd_val[7:0] = s.rx_mem[s.rx_rp];
                end
            end
            IDX_STATUS:
            begin
                rd_val[ST_TXCNT_LSB +: 5] = s.tx_cnt;
                rd_val[ST_RXCNT_LSB +: 5] = s.rx_cnt;
                rd_val[ST_TXREQ_BIT]      = tx_dma_request_n;
                rd_val[ST_RXREQ_BIT]      = rx_dma_request_n;
            end
            IDX_IRQ_STAT:
            begin
                rd_val[3:0] = s.irq_status;
            end
            IDX_IRQ_MASK:
            begin
                rd_val[3:0] = s.irq_mask;
            end
            default:
            begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // data phase write strobes
    assign wr_ctrl = s.ph_write & (s.ph_idx == IDX_FIFO_CTRL);
    assign wr_tx   = s.ph_write & (s.ph_idx == IDX_TX_DATA);
    assign wr_stat = s.ph_write & (s.ph_idx == IDX_IRQ_STAT);
    assign wr_mask = s.ph_write & (s.ph_idx == IDX_IRQ_MASK);

    // toggling the enable flushes both sides so stale bytes never leak across modes
    assign en_change = wr_ctrl & (hwdata[FC_EN_BIT] != s.fifo_en);
    assign tx_clr    = (wr_ctrl & hwdata[FC_EN_BIT] & hwdata[FC_TXCLR_BIT]) | en_change;
    assign rx_clr    = (wr_ctrl & hwdata[FC_EN_BIT] & hwdata[FC_RXCLR_BIT]) | en_change;

    // a write to a full tx side is dropped
    assign tx_push = wr_tx & (s.tx_cnt < cap);
    assign tx_pop  = tx_char_ready & (s.tx_cnt != 5'h00);
    assign rx_push = rx_char.valid & (s.rx_cnt < cap);
    assign rx_pop  = rd_rx;

    always_comb
    begin
        irq_set = 4'h0;
        irq_set[IRQ_RX_TRIG]  = rx_cond & ~s.rx_cond_d;
        irq_set[IRQ_TX_SPACE] = tx_cond & ~s.tx_cond_d;
        irq_set[IRQ_RX_TOUT]  = rx_timeout & s.fifo_en;
        irq_set[IRQ_RX_OVER]  = rx_char.valid & ~rx_push;
        irq_clr = wr_stat ? hwdata[3:0] : 4'h0;
    end

    always_comb
    begin
        next_s = s;
        next_s.ph_write = addr_ok & hwrite;
        next_s.ph_idx   = haddr[4:2];
        if (addr_ok & ~hwrite)
        begin
            next_s.rdata = rd_val;
        end

        // control register
        if (wr_ctrl)
        begin
            next_s.fifo_en = hwdata[FC_EN_BIT];
            if (hwdata[FC_EN_BIT])
            begin
                next_s.dma_mode = hwdata[FC_DMA_BIT];
                next_s.trig     = hwdata[FC_TRIG_LSB +: 2];
            end
        end
        if (wr_mask)
        begin
            next_s.irq_mask = hwdata[3:0];
        end

        // set wins over a write-one clear in the same cycle
        next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
        next_s.tx_cond_d  = tx_cond;
        next_s.rx_cond_d  = rx_cond;

        // tx fifo
        if (tx_push)
        begin
            next_s.tx_mem[s.tx_wp] = hwdata[7:0];
            next_s.tx_wp           = s.tx_wp + 4'h1;
        end
        if (tx_pop)
        begin
            next_s.tx_rp = s.tx_rp + 4'h1;
        end
        next_s.tx_cnt = s.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
        if (tx_clr)
        begin
            // only pointers and count reset; the shift register is outside
            next_s.tx_wp  = 4'h0;
            next_s.tx_rp  = 4'h0;
            next_s.tx_cnt = 5'h00;
        end

        // rx fifo
        if (rx_push)
        begin
            next_s.rx_mem[s.rx_wp] = rx_char.data;
            next_s.rx_wp           = s.rx_wp + 4'h1;
        end
        if (rx_pop)
        begin
            next_s.rx_rp = s.rx_rp + 4'h1;
        end
        next_s.rx_cnt = s.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
        if (rx_clr)
        begin
            // a character arriving in the clear cycle is lost with the rest
            next_s.rx_wp  = 4'h0;
            next_s.rx_rp  = 4'h0;
            next_s.rx_cnt = 5'h00;
        end

        // block mode rx request latch
        if (next_s.rx_cnt == 5'h00)
        begin
            next_s.rx_active = 1'b0;
        end
        else if ((next_s.rx_cnt >= trig_lvl) | rx_timeout)
        begin
            next_s.rx_active = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s            <= '0;
            s.fifo_en    <= 1'b0;
            s.dma_mode   <= 1'b0;
            s.trig       <= TRIG_RESET;
            s.tx_cond_d  <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule

// *** testbench/test_uart_fifo_control_dma_ready.sv ***
// Purpose: self-checking bench of the fifo control and dma ready block
// Assumes: zero-wait slave; link model plays the shift registers
// Notes:   drive after the rising edge, compare at the falling edge
`timescale 1ns/1ns
module test_uart_fifo_control_dma_ready
    import ufdma_pkg::*;
();
    typedef struct {logic [7:0] wr; logic [7:0] rd; int lvl; logic pre;} ufdma_row_t;
    ufdma_row_t  rows [5] = '{'{8'h03, 8'h01, 1, 1'h1}, '{8'h4B, 8'h49, 4, 1'h1}, '{8'h87, 8'h81, 8, 1'h0},
                              '{8'hFF, 8'hC9, 14, 1'h1}, '{8'h3A, 8'hC8, 1, 1'h1}};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_timeout, stall;
    logic        tx_dma_request_n, rx_dma_request_n, tx_irq_cond, rx_irq_cond, irq, tx_char_ready;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  last_tx;
    wire         hready = hreadyout;
    ufdma_char_t rx_char, tx_char;
    int          miscompares, n_checks;

    ufdma_top i_dut (.*);
    ufdma_link i_link (.hclk, .stall, .tx_char, .rx_char, .tx_char_ready, .last_tx);

    initial
    begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end
    task automatic complete_run(input logic hung);
        miscompares += hung;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic chk_pin(input string name, input logic exp, input logic got);
        chk(name, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'h1 && n < 20);
        if (n >= 20)
            complete_run(1'h1);
    endtask
    task automatic bus(input logic [2:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {27'h0, idx, 2'h0};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic drain(input int n, input logic [7:0] first);
        for (int i = 0; i < n; i++)
        begin
            bus(IDX_RX_DATA, 1'h0, 32'h0);
            chk("rx byte", {24'h0, first + 8'(i)}, rd);
        end
    endtask

    initial
    begin
        {hsel, hwrite, rx_timeout, stall, hresetn} = '0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(negedge hclk);
        chk_pin("tx request reset", 1'h0, tx_dma_request_n);
        chk_pin("rx request reset", 1'h1, rx_dma_request_n);
        bus(IDX_FIFO_CTRL, 1'h0, 32'h0);
        chk("fifo_control reset", 32'h0, rd);
        foreach (rows[i])
        begin
            bus(IDX_FIFO_CTRL, 1'h1, {24'h0, rows[i].wr});
            bus(IDX_FIFO_CTRL, 1'h0, 32'h0);
            chk("fifo_control", {24'h0, rows[i].rd}, rd);
            i_link.send(8'h10, rows[i].lvl - 1);
            @(negedge hclk);
            chk_pin("rx cond early", 1'h0, rx_irq_cond);
            chk_pin("rx request early", rows[i].pre, rx_dma_request_n);
            i_link.send(8'h30, 1);
            @(negedge hclk);
            chk_pin("rx cond", 1'h1, rx_irq_cond);
            chk_pin("rx request", 1'h0, rx_dma_request_n);
        end
        drain(1, 8'h30);
        @(negedge hclk);
        chk_pin("rx request popped", 1'h1, rx_dma_request_n);
        bus(3'h6, 1'h1, 32'hFFFF_FFFF);
        bus(3'h6, 1'h0, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk_pin("hresp okay", 1'h0, hresp);
        stall <= 1'h1;
        bus(IDX_TX_DATA, 1'h1, 32'hA5);
        @(negedge hclk);
        chk_pin("tx request loaded", 1'h1, tx_dma_request_n);
        @(posedge hclk);
        stall <= 1'h0;
        repeat (2) @(negedge hclk);
        chk_pin("tx request taken", 1'h0, tx_dma_request_n);
        chk("tx byte", 32'hA5, {24'h0, last_tx});
        @(posedge hclk);
        stall <= 1'h1;
        bus(IDX_FIFO_CTRL, 1'h1, 32'h09);
        for (int i = 1; i <= FIFO_DEPTH; i++)
        begin
            bus(IDX_TX_DATA, 1'h1, 32'(i));
            @(negedge hclk);
            chk_pin("tx request block", i == FIFO_DEPTH, tx_dma_request_n);
            chk_pin("tx cond block", i != FIFO_DEPTH, tx_irq_cond);
        end
        bus(IDX_STATUS, 1'h0, 32'h0);
        chk("tx count full", 32'h10, {27'h0, rd[4:0]});
        bus(IDX_FIFO_CTRL, 1'h1, 32'h0D);
        bus(IDX_STATUS, 1'h0, 32'h0);
        chk("tx count cleared", 32'h0, {27'h0, rd[4:0]});
        chk_pin("tx request cleared", 1'h0, rd[ST_TXREQ_BIT]);
        bus(IDX_FIFO_CTRL, 1'h1, 32'h4B);
        i_link.send(8'h50, 4);
        @(negedge hclk);
        chk_pin("rx block trigger", 1'h0, rx_dma_request_n);
        drain(1, 8'h50);
        @(negedge hclk);
        chk_pin("rx block held", 1'h0, rx_dma_request_n);
        chk_pin("rx cond below", 1'h0, rx_irq_cond);
        drain(3, 8'h51);
        @(negedge hclk);
        chk_pin("rx block empty", 1'h1, rx_dma_request_n);
        i_link.send(8'h60, 2);
        rx_timeout <= 1'h1;
        @(posedge hclk);
        rx_timeout <= 1'h0;
        @(negedge hclk);
        chk_pin("rx block timeout", 1'h0, rx_dma_request_n);
        bus(IDX_FIFO_CTRL, 1'h1, 32'hC3);
        i_link.send(8'h70, FIFO_DEPTH + 1);
        bus(IDX_STATUS, 1'h0, 32'h0);
        chk("rx count full", 32'h10, {27'h0, rd[12:8]});
        chk_pin("irq masked", 1'h0, irq);
        bus(IDX_IRQ_MASK, 1'h1, 32'h8);
        @(negedge hclk);
        chk_pin("irq overrun", 1'h1, irq);
        bus(IDX_IRQ_STAT, 1'h1, 32'h8);
        @(negedge hclk);
        chk_pin("irq cleared", 1'h0, irq);
        bus(IDX_FIFO_CTRL, 1'h1, 32'hC3);
        bus(IDX_STATUS, 1'h0, 32'h0);
        chk("rx count cleared", 32'h0, {27'h0, rd[12:8]});
        chk_pin("rx cond cleared", 1'h0, rx_irq_cond);
        complete_run(1'h0);
    end
endmodule

// *** testbench/ufdma_link.sv ***
// Purpose: link-side model in place of the tx and rx shift registers
// Assumes: at most one character a cycle, same clock as the bus
// Notes:   stall holds off the tx side so the fifo can fill
`timescale 1ns/1ns
module ufdma_link
    import ufdma_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        stall,
    input  wire ufdma_char_t tx_char,
    output ufdma_char_t      rx_char,
    output logic             tx_char_ready,
    output logic [7:0]       last_tx
);
    initial rx_char = '{valid: 1'h0, data: 8'hFF};
    assign tx_char_ready = !stall;
    always_ff @(posedge hclk)
        if (tx_char.valid && tx_char_ready)
            last_tx <= tx_char.data;
    task automatic send(input logic [7:0] first, input int n);
        @(posedge hclk);
        for (int i = 0; i < n; i++)
        begin
            rx_char <= '{valid: 1'h1, data: first + 8'(i)};
            @(posedge hclk);
        end
        // inverted byte outside a beat, so a stale value is never mistaken for data
        rx_char <= '{valid: 1'h0, data: ~rx_char.data};
    endtask
endmodule

// *** testbench/ufdma_monitor.sv ***
// Purpose: pin relations of the fifo control and dma ready block
// Assumes: enable, mode and trigger are followed by snooping control writes
// Notes:   fifo counts stay hidden, so pins are checked against each other
`timescale 1ns/1ns
module ufdma_monitor
    import ufdma_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire ufdma_char_t rx_char,
    input wire logic        rx_timeout,
    input wire ufdma_char_t tx_char,
    input wire logic        tx_dma_request_n,
    input wire logic        rx_dma_request_n,
    input wire logic        tx_irq_cond,
    input wire logic        rx_irq_cond
);
    logic       wc, wt, en, md;
    logic [1:0] tg;
    wire        blk = en && md;
    wire        acc = hsel && hready && htrans == HTRANS_NONSEQ;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {wc, wt, en, md, tg} <= '0;
        else
        begin
            wc <= acc && hwrite && haddr[4:2] == IDX_FIFO_CTRL;
            wt <= acc && hwrite && haddr[4:2] == IDX_TX_DATA;
            // a write with the enable bit low moves only the enable
            if (wc)
                {en, md, tg} <= hwdata[FC_EN_BIT] ? {1'h1, hwdata[FC_DMA_BIT], hwdata[FC_TRIG_LSB +: 2]} : {1'h0, md, tg};
        end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_blk_held;
        blk && $past(blk);
    endsequence
    a_tx_single: assert property (!blk |-> tx_dma_request_n == tx_char.valid)
        else $error("tx request wrong in single mode");
    a_tx_empty: assert property (!blk |-> tx_irq_cond == !tx_char.valid)
        else $error("tx condition wrong in single mode");
    a_tx_block: assert property (blk |-> tx_dma_request_n == !tx_irq_cond)
        else $error("tx request wrong in block mode");
    a_rx_off: assert property (!en |-> rx_dma_request_n == !rx_irq_cond)
        else $error("rx request wrong with fifos off");
    a_rx_one_char: assert property (en && !md && tg == TRIG_RESET
        |-> rx_dma_request_n == !rx_irq_cond) else $error("rx request wrong at one-character trigger");
    a_rx_block: assert property (s_blk_held ##0 rx_irq_cond |-> ##[0:1] !rx_dma_request_n)
        else $error("rx request high past trigger");
    a_tx_rise_cause: assert property ($rose(tx_dma_request_n) && $stable(en) && $stable(md)
        |-> $past(wt)) else $error("tx request rose without a push");
    a_rx_fall_cause: assert property ($fell(rx_dma_request_n) && $stable({en, md, tg})
        |-> $past(rx_char.valid) || $past(rx_timeout)) else $error("rx request fell without a cause");
endmodule

bind ufdma_top ufdma_monitor i_mon (.*);
